// ==== hdl/ict_sequencer.sv ====
// Instruction cycle timing sequencer: steps T-states and machine cycles of one
// instruction, inserting automatic and requested wait states.
// Assumes start, class, condition and wait request are synchronous to clk.
`timescale 1ns/1ps
`include "ict_defs.svh"

module ict_sequencer (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire ict_pkg::ict_class_e op_class,
	input wire logic cond_met,
	input wire logic wait_req,
	output logic busy,
	output logic done,
	output logic [2:0] m_cycle,
	output logic [2:0] t_state,
	output logic in_wait,
	output logic io_cycle,
	output logic [7:0] states_total,
	output logic [7:0] waits_total,
	output logic [2:0] instr_bytes,
	output logic [4:0] base_states
);
	import ict_pkg::*;

	ict_seq_s s_q;
	ict_seq_s s_d;
	logic tick;
	logic [2:0] cur_len;
	logic [2:0] cur_mcnt;
	logic [2:0] nx_bytes;
	logic [2:0] nx_len_unused;
	logic [2:0] nx_mcnt_unused;
	logic [4:0] cur_total_unused;
	logic [2:0] cur_bytes_unused;
	logic cur_io_unused;
	logic nx_io;
	logic [4:0] nx_base;
	ict_class_e nx_cls;
	logic nx_cond;
	logic [2:0] nx_m;

	// ************************************************************
	// Table lookups: current machine cycle, and the one to come
	// ************************************************************
	ict_cycle_table u_cur (
		.cls(s_q.cls),
		.cond(s_q.cond),
		.m_idx(s_q.m_idx),
		.bytes(cur_bytes_unused),
		.mcnt(cur_mcnt),
		.len(cur_len),
		.io(cur_io_unused),
		.total(cur_total_unused)
	);

	// While idle the second lookup previews the incoming instruction
	assign nx_cls = (s_q.st == ICT_RUN) ? s_q.cls : op_class;
	assign nx_cond = (s_q.st == ICT_RUN) ? s_q.cond : cond_met;
	assign nx_m = (s_q.st == ICT_RUN) ? 3'(s_q.m_idx + 3'h1) : 3'h0;

	ict_cycle_table u_nxt (
		.cls(nx_cls),
		.cond(nx_cond),
		.m_idx(nx_m),
		.bytes(nx_bytes),
		.mcnt(nx_mcnt_unused),
		.len(nx_len_unused),
		.io(nx_io),
		.total(nx_base)
	);

	// T-state enable from the clock divider
	assign tick = (s_q.div == 4'(`ICT_TS_CYC - 1));

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			ICT_IDLE: begin
				s_d.div = 4'h0;
				// Flags are taken as the instruction starts, so the path is fixed
				if (start) begin
					s_d.st = ICT_RUN;
					s_d.cls = op_class;
					s_d.cond = cond_met;
					s_d.m_idx = 3'h0;
					s_d.t_idx = 3'h0;
					s_d.auto_pend = nx_io;
					s_d.io = nx_io;
					s_d.in_wait = 1'b0;
					s_d.busy = 1'b1;
					s_d.states = 8'h00;
					s_d.waits = 8'h00;
					s_d.bytes = nx_bytes;
					s_d.base = nx_base;
				end
			end
			ICT_RUN: begin
				s_d.div = tick ? 4'h0 : 4'(s_q.div + 4'h1);
				if (tick) begin
					s_d.states = 8'(s_q.states + 8'h01);
					// Wait slot after T2: automatic I/O wait first, then requested ones
					if (s_q.t_idx == 3'(`ICT_WAIT_SLOT) && (s_q.auto_pend || wait_req)) begin
						s_d.in_wait = 1'b1;
						s_d.auto_pend = 1'b0;
						s_d.waits = 8'(s_q.waits + 8'h01);
					end else begin
						s_d.in_wait = 1'b0;
						if (s_q.t_idx == 3'(cur_len - 3'h1)) begin
							if (s_q.m_idx == 3'(cur_mcnt - 3'h1)) begin
								s_d.st = ICT_IDLE;
								s_d.busy = 1'b0;
								s_d.done = 1'b1;
								s_d.io = 1'b0;
							end else begin
								s_d.m_idx = 3'(s_q.m_idx + 3'h1);
								s_d.t_idx = 3'h0;
								s_d.auto_pend = nx_io;
								s_d.io = nx_io;
							end
						end else begin
							s_d.t_idx = 3'(s_q.t_idx + 3'h1);
						end
					end
				end
			end
			default: begin
				s_d.st = ICT_IDLE;
				s_d.busy = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register
	assign busy = s_q.busy;
	assign done = s_q.done;
	assign m_cycle = s_q.m_idx;
	assign t_state = s_q.t_idx;
	assign in_wait = s_q.in_wait;
	assign io_cycle = s_q.io;
	assign states_total = s_q.states;
	assign waits_total = s_q.waits;
	assign instr_bytes = s_q.bytes;
	assign base_states = s_q.base;

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence seq_accept;
		(s_q.st == ICT_IDLE) && start;
	endsequence

	sequence seq_wait_tick;
		busy && tick && (t_state == 3'(`ICT_WAIT_SLOT)) && wait_req && !s_q.auto_pend;
	endsequence

	a_hl_jump: assert property (done && s_q.cls == ICT_JP_HL && waits_total == 8'h00
		|-> states_total == 8'(`ICT_ST_JP_HL) && instr_bytes == 3'h1 && m_cycle == 3'h0)
		else $error("HL jump length wrong");
	a_idx_jump: assert property (done && s_q.cls == ICT_JP_IDX && waits_total == 8'h00
		|-> states_total == 8'(`ICT_ST_JP_IDX) && instr_bytes == 3'h2 && m_cycle == 3'h1)
		else $error("index jump length wrong");
	a_vector_xfer: assert property (done && s_q.cls == ICT_XFER_IV && waits_total == 8'h00
		|-> states_total == 8'(`ICT_ST_XFER))
		else $error("vector transfer length wrong");
	a_refresh_xfer: assert property (done && s_q.cls == ICT_XFER_RF && waits_total == 8'h00
		|-> states_total == 8'(`ICT_ST_XFER))
		else $error("refresh transfer length wrong");
	a_block_io: assert property (done && s_q.cls == ICT_BLK_IO
		|-> states_total == 8'(8'(`ICT_ST_BLK_IO) + waits_total - 8'h01) && m_cycle == 3'h3)
		else $error("block I/O length wrong");
	a_cond_path: assert property (seq_accept ##1 (busy && s_q.cls == ICT_JR && !s_q.cond)
		|-> base_states == 5'(`ICT_ST_JR_NOT))
		else $error("unmet condition path wrong");
	a_tick_rate: assert property (busy |-> tick)
		else $error("T-state enable not every clock");
	// The automatic I/O wait is already inside the listed base, so it is taken out once here
	a_total_sum: assert property (done |-> states_total ==
		8'(base_states + waits_total - ((s_q.cls == ICT_BLK_IO) ? 8'h01 : 8'h00)))
		else $error("total differs from base plus waits");
	a_io_auto: assert property (done && s_q.cls == ICT_BLK_IO |-> waits_total >= 8'h01)
		else $error("I/O cycle missing automatic wait");
	a_auto_io: assert property (busy && tick && io_cycle && !in_wait
		&& t_state == 3'(`ICT_WAIT_SLOT) |=> in_wait)
		else $error("I/O cycle did not insert its own wait");
	a_wait_one: assert property (seq_wait_tick |=> in_wait && t_state == $past(t_state)
		&& states_total == 8'($past(states_total) + 8'h01))
		else $error("wait did not add one T-state");
	a_req_adds: assert property (seq_wait_tick |=> waits_total == 8'($past(waits_total) + 8'h01))
		else $error("requested wait not counted");

endmodule : ict_sequencer

// ==== hdl/ict_defs.svh ====
// Timing constants for the instruction cycle timing sequencer.
// Assumes one core clock; every T-state is a whole number of core clocks.
`ifndef ICT_DEFS_SVH
`define ICT_DEFS_SVH

// ************************************************************
// Clock and T-state
// ************************************************************
`define ICT_CLK_NS 40
`define ICT_TSTATE_NS 40
// Clocks per T-state, rounded up, never below one
`define ICT_TS_CYC (((`ICT_TSTATE_NS + `ICT_CLK_NS - 1) / `ICT_CLK_NS) < 1 ? 1 : \
	((`ICT_TSTATE_NS + `ICT_CLK_NS - 1) / `ICT_CLK_NS))

// ************************************************************
// Machine cycle lengths in T-states (I/O base excludes its own wait)
// ************************************************************
`define ICT_M1_LEN 4
`define ICT_MEM_LEN 3
`define ICT_IO_BASE 3
`define ICT_LONG_LEN 5
`define ICT_SHORT_LEN 2
`define ICT_TINY_LEN 1
`define ICT_WAIT_SLOT 1

// ************************************************************
// Instruction totals in T-states with no requested waits
// ************************************************************
`define ICT_ST_JP_HL 4
`define ICT_ST_JP_IDX 6
`define ICT_ST_XFER 9
`define ICT_ST_BLK_IO 18
`define ICT_ST_JP_DIR 10
`define ICT_ST_JR_MET 12
`define ICT_ST_JR_NOT 7
`define ICT_ST_CALL_MET 17
`define ICT_ST_CALL_NOT 10

`endif

// ==== hdl/ict_pkg.sv ====
// Types for the instruction cycle timing sequencer.
// Assumes ict_defs.svh holds the numbers.
package ict_pkg;

	// ************************************************************
	// Instruction timing classes
	// ************************************************************
	typedef enum logic [2:0] {
		ICT_JP_HL,
		ICT_JP_IDX,
		ICT_XFER_IV,
		ICT_XFER_RF,
		ICT_BLK_IO,
		ICT_JP_DIR,
		ICT_JR,
		ICT_CALL
	} ict_class_e;

	typedef enum logic {
		ICT_IDLE,
		ICT_RUN
	} ict_state_e;

	// Whole state of the sequencer
	typedef struct packed {
		ict_state_e st;
		ict_class_e cls;
		logic cond;
		logic [3:0] div;
		logic [2:0] m_idx;
		logic [2:0] t_idx;
		logic auto_pend;
		logic in_wait;
		logic io;
		logic busy;
		logic done;
		logic [7:0] states;
		logic [7:0] waits;
		logic [2:0] bytes;
		logic [4:0] base;
	} ict_seq_s;

endpackage : ict_pkg

// ==== hdl/ict_cycle_table.sv ====
// Lookup of bytes, machine cycles and per-cycle T-state lengths per class.
// Assumes the caller holds the class, condition and machine cycle index.
`timescale 1ns/1ps
`include "ict_defs.svh"

module ict_cycle_table (
	input wire ict_pkg::ict_class_e cls,
	input wire logic cond,
	input wire logic [2:0] m_idx,
	output logic [2:0] bytes,
	output logic [2:0] mcnt,
	output logic [2:0] len,
	output logic io,
	output logic [4:0] total
);
	import ict_pkg::*;

	// Five three-bit lengths, machine cycle 0 in the low bits
	logic [14:0] lens;
	logic [2:0] io_m;
	logic has_io;

	// ************************************************************
	// Class decode; met and unmet conditions take separate paths
	// ************************************************************
	always_comb begin
		lens = 15'h0000;
		io_m = 3'h0;
		has_io = 1'b0;
		bytes = 3'h1;
		mcnt = 3'h1;
		total = 5'(`ICT_ST_JP_HL);
		case (cls)
			ICT_JP_HL: begin
				lens = {12'h000, 3'(`ICT_M1_LEN)};
			end
			ICT_JP_IDX: begin
				bytes = 3'h2;
				mcnt = 3'h2;
				lens = {9'h000, 3'(`ICT_SHORT_LEN), 3'(`ICT_M1_LEN)};
				total = 5'(`ICT_ST_JP_IDX);
			end
			ICT_XFER_IV, ICT_XFER_RF: begin
				bytes = 3'h2;
				mcnt = 3'h2;
				lens = {9'h000, 3'(`ICT_LONG_LEN), 3'(`ICT_M1_LEN)};
				total = 5'(`ICT_ST_XFER);
			end
			ICT_BLK_IO: begin
				bytes = 3'h2;
				mcnt = 3'h4;
				lens = {3'h0, 3'(`ICT_LONG_LEN), 3'(`ICT_IO_BASE), 3'(`ICT_LONG_LEN),
					3'(`ICT_M1_LEN)};
				io_m = 3'h2;
				has_io = 1'b1;
				total = 5'(`ICT_ST_BLK_IO);
			end
			ICT_JP_DIR: begin
				bytes = 3'h3;
				mcnt = 3'h3;
				lens = {6'h00, 3'(`ICT_MEM_LEN), 3'(`ICT_MEM_LEN), 3'(`ICT_M1_LEN)};
				total = 5'(`ICT_ST_JP_DIR);
			end
			ICT_JR: begin
				bytes = 3'h2;
				mcnt = 3'h3;
				if (cond) begin
					lens = {6'h00, 3'(`ICT_LONG_LEN), 3'(`ICT_MEM_LEN), 3'(`ICT_M1_LEN)};
					total = 5'(`ICT_ST_JR_MET);
				end else begin
					lens = {6'h00, 3'(`ICT_TINY_LEN), 3'(`ICT_SHORT_LEN), 3'(`ICT_M1_LEN)};
					total = 5'(`ICT_ST_JR_NOT);
				end
			end
			ICT_CALL: begin
				bytes = 3'h3;
				if (cond) begin
					mcnt = 3'h5;
					lens = {3'(`ICT_MEM_LEN), 3'(`ICT_MEM_LEN), 3'(`ICT_M1_LEN), 3'(`ICT_MEM_LEN),
						3'(`ICT_M1_LEN)};
					total = 5'(`ICT_ST_CALL_MET);
				end else begin
					mcnt = 3'h3;
					lens = {6'h00, 3'(`ICT_MEM_LEN), 3'(`ICT_MEM_LEN), 3'(`ICT_M1_LEN)};
					total = 5'(`ICT_ST_CALL_NOT);
				end
			end
			default: begin
				lens = {12'h000, 3'(`ICT_M1_LEN)};
			end
		endcase
	end

	// Length and I/O flag of the selected machine cycle; out of range reads as zero
	always_comb begin
		len = 3'h0;
		if (m_idx < 3'h5) begin
			len = lens[m_idx * 3 +: 3];
		end
		io = has_io && (m_idx == io_m);
	end

endmodule : ict_cycle_table

// ==== verif/ict_prog_model.sv ====
// Program-side model: issues instructions to the sequencer and answers with wait requests.
// Assumes it shares clk with the sequencer and is used only after reset is released.
`timescale 1ns/1ps

module ict_prog_model (
	input wire logic clk,
	input wire logic busy,
	input wire logic done,
	input wire logic [2:0] t_state,
	input wire logic in_wait,
	input wire logic io_cycle,
	output ict_pkg::ict_class_e op_class,
	output logic start,
	output logic cond_met,
	output logic wait_req
);
	import ict_pkg::*;

	int wk = 0;
	int n_wait = 0;
	int n_io = 0;

	// Clocks spent in wait states and in I/O cycles while an instruction runs
	always @(negedge clk) begin
		if (busy) begin
			if (in_wait) begin
				n_wait++;
			end
			if (io_cycle) begin
				n_io++;
			end
		end
	end

	// Quiet bus at time zero
	initial begin
		start = 1'b0;
		op_class = ICT_JP_HL;
		cond_met = 1'b0;
		wait_req = 1'b0;
	end

	// Request only in the slot state; a held request adds one state per clock
	always @(negedge clk) begin
		wait_req = busy && (t_state == 3'h1) && (wk > 0);
	end

	// One pending wait used up per sampled request
	always @(posedge clk) begin
		if (wait_req && busy) begin
			wk--;
		end
	end

	// Issue one instruction; n counts clocks from the taking edge up to done
	task automatic run(input ict_class_e c, input logic cm, input int k, input int poke, output int n);
		n_wait = 0;
		n_io = 0;
		op_class = c;
		cond_met = cm;
		wk = k;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
			if (done !== 1'b1) begin
				start = (n == poke); // Stray request while busy
			end
		end
	endtask : run

endmodule : ict_prog_model

// ==== verif/instruction_cycle_timing_tb.sv ====
// Testbench for the instruction cycle timing sequencer.
// Assumes one T-state per clock and the program model on the request side.
`timescale 1ns/1ps

module instruction_cycle_timing_tb;
	import ict_pkg::*;

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("mismatch %s expected %0d seen %0d", nm, e, g); end end

	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic start, cond_met, wait_req, busy, done, in_wait, io_cycle;
	ict_class_e op_class;
	logic [2:0] m_cycle, t_state, instr_bytes;
	logic [7:0] states_total, waits_total;
	logic [4:0] base_states;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;

	ict_sequencer i_dut (.clk(clk), .reset_n(reset_n), .start(start), .op_class(op_class),
		.cond_met(cond_met), .wait_req(wait_req), .busy(busy), .done(done), .m_cycle(m_cycle),
		.t_state(t_state), .in_wait(in_wait), .io_cycle(io_cycle), .states_total(states_total),
		.waits_total(waits_total), .instr_bytes(instr_bytes), .base_states(base_states));

	ict_prog_model i_prog (.clk(clk), .busy(busy), .done(done), .t_state(t_state),
		.in_wait(in_wait), .io_cycle(io_cycle),
		.op_class(op_class), .start(start), .cond_met(cond_met), .wait_req(wait_req));

	// ************************************************************
	// Clock, timeout and verdict
	// ************************************************************
	always #20 clk = ~clk;

	// Whole run is under two hundred clocks; the ceiling leaves wide margin
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test

	// ************************************************************
	// Scenarios
	// ************************************************************
	// One instruction, judged on clocks taken and all reported totals
	// mc is the machine cycle count, io the clocks spent in the I/O cycle
	task automatic go(ict_class_e c, logic cm, int k, int poke, int base, int by, int mc, int aw, int io);
		int n;
		i_prog.run(c, cm, k, poke, n);
		`CHK("clocks", base + k + 1, n)
		`CHK("states", base + k, states_total)
		`CHK("base", base, base_states)
		`CHK("bytes", by, instr_bytes)
		`CHK("m_cycle", mc - 1, m_cycle)
		`CHK("waits", aw + k, waits_total)
		`CHK("wait_clocks", aw + k, i_prog.n_wait)
		`CHK("io_clocks", io, i_prog.n_io)
	endtask : go

	task automatic t_fixed();
		go(ICT_JP_HL, 1'b0, 0, 0, 4, 1, 1, 0, 0);
		go(ICT_JP_IDX, 1'b0, 0, 0, 6, 2, 2, 0, 0);
		go(ICT_XFER_IV, 1'b0, 0, 0, 9, 2, 2, 0, 0);
		go(ICT_XFER_RF, 1'b1, 0, 0, 9, 2, 2, 0, 0);
		go(ICT_BLK_IO, 1'b0, 0, 0, 18, 2, 4, 1, 4);
		go(ICT_JP_DIR, 1'b1, 0, 0, 10, 3, 3, 0, 0);
		$display("test fixed done");
	endtask : t_fixed

	task automatic t_cond();
		go(ICT_JR, 1'b1, 0, 0, 12, 2, 3, 0, 0);
		go(ICT_JR, 1'b0, 0, 0, 7, 2, 3, 0, 0);
		go(ICT_CALL, 1'b1, 0, 0, 17, 3, 5, 0, 0);
		go(ICT_CALL, 1'b0, 0, 0, 10, 3, 3, 0, 0);
		$display("test cond done");
	endtask : t_cond

	// Requested waits add to the automatic one; the model asks for them in the first machine cycle
	task automatic t_wait();
		go(ICT_JP_HL, 1'b0, 2, 0, 4, 1, 1, 0, 0);
		go(ICT_BLK_IO, 1'b0, 1, 0, 18, 2, 4, 1, 4);
		$display("test wait done");
	endtask : t_wait

	// A stray start mid-run is ignored; the next start may come with done
	task automatic t_busy();
		go(ICT_JP_DIR, 1'b0, 0, 4, 10, 3, 3, 0, 0);
		go(ICT_JP_HL, 1'b0, 0, 0, 4, 1, 1, 0, 0);
		$display("test busy done");
	endtask : t_busy

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		`CHK("busy_idle", 1'b0, busy)
		t_fixed();
		t_cond();
		t_wait();
		t_busy();
		finish_test();
	end

endmodule : instruction_cycle_timing_tb
